//--- adc_far_end_model.sv
// far-end model: conversion engine that ends restart and abort events
`timescale 1ns/1ns
module adc_far_end_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	// status seen from the block, and pacing
	input  wire logic       restart_active_i,
	input  wire logic       abort_in_progress_i,
	input  wire logic [3:0] delay_i,
	// completion pulses
	output logic            restart_done_o,
	output logic            abort_done_o
);
	logic [3:0] rcnt_q;
	logic [3:0] acnt_q;
	// ------------------------------------------------------------
	// completion pacing
	// ------------------------------------------------------------
	// falling edge, like all other stimulus; a large delay_i leaves room for overruns
	always @(negedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rcnt_q         <= 4'h0;
			acnt_q         <= 4'h0;
			restart_done_o <= 1'b0;
			abort_done_o   <= 1'b0;
		end else begin
			restart_done_o <= restart_active_i && !restart_done_o && rcnt_q == delay_i;
			abort_done_o   <= abort_in_progress_i && !abort_done_o && acnt_q == delay_i;
			rcnt_q         <= (restart_active_i && rcnt_q != delay_i) ? rcnt_q + 4'h1 : 4'h0;
			acnt_q         <= (abort_in_progress_i && acnt_q != delay_i) ? acnt_q + 4'h1 : 4'h0;
		end
	end
endmodule : adc_far_end_model

//--- adc_ovr_pkg.sv
// shared constants for the converter sequence overrun control
package adc_ovr_pkg;

	// ------------------------------------------------------------
	// field widths and the flag index range
	// ------------------------------------------------------------
	localparam int unsigned FLAG_SEL_W  = 4;
	localparam int unsigned FLAG_HI     = 15;
	localparam int unsigned FLAG_LO     = 1;
	localparam int unsigned CMD_INDEX_W = 6;

	// ------------------------------------------------------------
	// reset values and the no-flag select code
	// ------------------------------------------------------------
	localparam logic [FLAG_SEL_W-1:0]  FLAG_SEL_NONE = 4'h0;
	localparam logic [CMD_INDEX_W-1:0] INDEX_RESET   = 6'h00;
	localparam logic                   BIT_RESET     = 1'b0;

	// ------------------------------------------------------------
	// restart sequencing states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RS_IDLE   = 3'b001,
		RS_BUSY   = 3'b010,
		RS_REPLAY = 3'b100
	} restart_state_e;

endpackage : adc_ovr_pkg

//--- adc_sequence_overrun_control.sv
// overrun handling for restart, reload, conversion request and abort events
// How it works
// - fresh restart with none in progress sets restart_active
// - restart request while restart_active is set counts as an overrun
// - one background slot keeps only the latest overrun restart
// - pending restart replays, restart_active set one cycle after clearing
// - each restart overrun with reload_confirm high sets reload background bit
// - reload background bit clears when the pending restart is taken
// - request while pending sets error flag, halt at next boundary
// - auto mode coincident hardware and bus/interface requests halt before sampling
// - in auto mode a restart overrun leaves the error flag alone
// - abort request during abort_in_progress is discarded
// - stored command with nonzero flag select captures index and sets flag
`timescale 1ns/1ns
module adc_sequence_overrun_control (
	// clock and reset
	input  wire logic                                   clk_i,
	input  wire logic                                   reset_n_i,
	// restart requests and completion
	input  wire logic                                   restart_req_i,
	input  wire logic                                   restart_done_i,
	input  wire logic                                   reload_confirm_i,
	// conversion requests
	input  wire logic                                   auto_request_mode_i,
	input  wire logic                                   conv_req_bus_i,
	input  wire logic                                   conv_req_intf_i,
	input  wire logic                                   conv_start_i,
	input  wire logic                                   conv_boundary_i,
	input  wire logic                                   overrun_clear_i,
	// sequence abort
	input  wire logic                                   abort_req_i,
	input  wire logic                                   abort_done_i,
	// command completion
	input  wire logic                                   cmd_stored_i,
	input  wire logic [adc_ovr_pkg::FLAG_SEL_W-1:0]     flag_select_field_i,
	input  wire logic [adc_ovr_pkg::CMD_INDEX_W-1:0]    cmd_index_i,
	input  wire logic [adc_ovr_pkg::FLAG_HI:adc_ovr_pkg::FLAG_LO] done_flag_clear_i,
	// restart status
	output logic                                        restart_active_o,
	output logic                                        restart_pending_o,
	output logic                                        reload_confirm_bg_o,
	output logic                                        restart_start_o,
	output logic                                        restart_reload_o,
	output logic                                        restart_overrun_o,
	// conversion request status
	output logic                                        conversion_request_pending_o,
	output logic                                        request_overrun_error_flag_o,
	output logic                                        halt_o,
	// abort status
	output logic                                        abort_in_progress_o,
	output logic                                        abort_start_o,
	output logic                                        abort_discard_o,
	// command completion status
	output logic [adc_ovr_pkg::CMD_INDEX_W-1:0]         interrupt_index_capture_o,
	output logic [adc_ovr_pkg::FLAG_HI:adc_ovr_pkg::FLAG_LO] conversion_done_flags_o
);

	// ------------------------------------------------------------
	// restart sequencing
	// ------------------------------------------------------------
	adc_ovr_pkg::restart_state_e state_q;
	adc_ovr_pkg::restart_state_e state_d;
	logic                        pending_q;
	logic                        pending_d;
	logic                        reload_bg_q;
	logic                        reload_bg_d;
	logic                        restart_busy;
	logic                        restart_overrun;
	logic                        restart_fresh;
	logic                        restart_take;
	logic                        restart_begin;
	logic                        restart_reload_d;

	assign restart_busy = (state_q == adc_ovr_pkg::RS_BUSY) | (state_q == adc_ovr_pkg::RS_REPLAY);
	assign restart_overrun = restart_req_i & restart_busy;
	assign restart_fresh = restart_req_i & (state_q == adc_ovr_pkg::RS_IDLE);
	// pending request is taken in the cycle restart_active clears
	assign restart_take  = (state_q == adc_ovr_pkg::RS_BUSY) & restart_done_i & pending_q;
	assign restart_begin = restart_fresh | (state_q == adc_ovr_pkg::RS_REPLAY);

	// replay state gives the one-cycle gap
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			adc_ovr_pkg::RS_IDLE: begin
				if (restart_fresh) begin
					state_d = adc_ovr_pkg::RS_BUSY;
				end
			end
			adc_ovr_pkg::RS_BUSY: begin
				if (restart_done_i) begin
					state_d = pending_q ? adc_ovr_pkg::RS_REPLAY : adc_ovr_pkg::RS_IDLE;
				end
			end
			adc_ovr_pkg::RS_REPLAY: begin
				state_d = adc_ovr_pkg::RS_BUSY;
			end
			default: begin
				state_d = adc_ovr_pkg::RS_IDLE;
			end
		endcase
	end

	// single slot, newest overrun overwrites and beats the take
	assign pending_d = restart_overrun | (pending_q & ~restart_take);

	// reload background capture, capture beats the clear
	assign reload_bg_d = (restart_overrun & reload_confirm_i) | (reload_bg_q & ~restart_take);

	// reload state handed over with the start: live input or held copy
	assign restart_reload_d = restart_fresh ? reload_confirm_i : reload_bg_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= adc_ovr_pkg::RS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// replayed restarts must carry the reload state taken at the overrun,
	// so the copy is latched on the take and not on the replay cycle
	logic replay_reload_q;
	logic replay_reload_d;

	assign replay_reload_d = restart_take ? reload_bg_q : replay_reload_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pending_q        <= adc_ovr_pkg::BIT_RESET;
			reload_bg_q      <= adc_ovr_pkg::BIT_RESET;
			replay_reload_q  <= adc_ovr_pkg::BIT_RESET;
			restart_active_o <= adc_ovr_pkg::BIT_RESET;
			restart_pending_o   <= adc_ovr_pkg::BIT_RESET;
			reload_confirm_bg_o <= adc_ovr_pkg::BIT_RESET;
			restart_start_o     <= adc_ovr_pkg::BIT_RESET;
			restart_reload_o    <= adc_ovr_pkg::BIT_RESET;
			restart_overrun_o   <= adc_ovr_pkg::BIT_RESET;
		end else begin
			pending_q        <= pending_d;
			reload_bg_q      <= reload_bg_d;
			replay_reload_q  <= replay_reload_d;
			restart_active_o <= (state_d == adc_ovr_pkg::RS_BUSY);
			restart_pending_o   <= pending_d;
			reload_confirm_bg_o <= reload_bg_d;
			restart_start_o     <= restart_begin;
			restart_reload_o    <= restart_fresh ? restart_reload_d : replay_reload_q;
			restart_overrun_o   <= restart_overrun;
		end
	end

	chk_fresh_sets_active: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		restart_fresh |=> restart_active_o) else $error("fresh restart did not set active");
	// replay sets active after one idle cycle
	chk_replay_gap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		restart_take |=> !restart_active_o ##1 restart_active_o) else $error("replay gap wrong");
	chk_overrun_pending: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		restart_overrun |=> restart_pending_o) else $error("overrun not held pending");
	// take clears reload background without a new capture
	chk_reload_cleared: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(restart_take && !restart_overrun) |=> !reload_confirm_bg_o) else $error("reload bg not cleared");
	chk_reload_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(restart_overrun && reload_confirm_i) |=> reload_confirm_bg_o) else $error("reload bg not captured");

	// ------------------------------------------------------------
	// conversion request overrun
	// ------------------------------------------------------------
	logic req_pending_q;
	logic req_pending_d;
	logic stop_req_q;
	logic stop_req_d;
	logic halt_d;
	logic hw_req;
	logic sw_req;
	logic any_req;
	logic req_collide;
	logic req_overrun;

	// only started restarts raise the hardware request
	assign hw_req = auto_request_mode_i & restart_begin;
	assign sw_req = conv_req_bus_i | conv_req_intf_i;
	assign any_req = hw_req | sw_req;
	assign req_collide = hw_req & sw_req;
	assign req_overrun = (any_req & req_pending_q & ~conv_start_i) | req_collide;

	// a request in the consume cycle becomes the next pending one
	assign req_pending_d = any_req | (req_pending_q & ~conv_start_i);

	// cease at next boundary, held until software clears
	// a new overrun in the clear cycle wins so it is never lost
	assign stop_req_d = req_overrun | (stop_req_q & ~overrun_clear_i);
	// collision halts at once, before sampling begins
	assign halt_d = req_collide | (stop_req_q & conv_boundary_i) | (halt_o & ~overrun_clear_i);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_pending_q                <= adc_ovr_pkg::BIT_RESET;
			stop_req_q                   <= adc_ovr_pkg::BIT_RESET;
			halt_o                       <= adc_ovr_pkg::BIT_RESET;
			conversion_request_pending_o <= adc_ovr_pkg::BIT_RESET;
		end else begin
			req_pending_q                <= req_pending_d;
			stop_req_q                   <= stop_req_d;
			halt_o                       <= halt_d;
			conversion_request_pending_o <= req_pending_d;
		end
	end

	sticky_flag u_error_flag (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.set_i     (req_overrun),
		.clear_i   (overrun_clear_i),
		.flag_o    (request_overrun_error_flag_o)
	);

	chk_overrun_flags: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		req_overrun |=> request_overrun_error_flag_o) else $error("overrun flag missing");
	chk_collide_halts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		req_collide |=> halt_o) else $error("collision did not halt");
	// restart overrun alone does not flag
	chk_restart_no_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(restart_overrun && !sw_req && !restart_begin && !request_overrun_error_flag_o)
		|=> !request_overrun_error_flag_o) else $error("restart overrun flagged");

	// ------------------------------------------------------------
	// sequence abort
	// ------------------------------------------------------------
	logic abort_q;
	logic abort_d;
	logic abort_accept;

	// requests during an abort are dropped
	assign abort_accept = abort_req_i & ~abort_q;
	assign abort_d = abort_accept | (abort_q & ~abort_done_i);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			abort_q             <= adc_ovr_pkg::BIT_RESET;
			abort_in_progress_o <= adc_ovr_pkg::BIT_RESET;
			abort_start_o       <= adc_ovr_pkg::BIT_RESET;
			abort_discard_o     <= adc_ovr_pkg::BIT_RESET;
		end else begin
			abort_q             <= abort_d;
			abort_in_progress_o <= abort_d;
			abort_start_o       <= abort_accept;
			abort_discard_o     <= abort_req_i & abort_q;
		end
	end

	chk_abort_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(abort_req_i && abort_q) |=> !abort_start_o && abort_discard_o) else $error("abort not discarded");

	// ------------------------------------------------------------
	// command completion flags
	// ------------------------------------------------------------
	logic                                  cmd_flagged;
	logic [adc_ovr_pkg::CMD_INDEX_W-1:0]   index_d;

	assign cmd_flagged = cmd_stored_i & (flag_select_field_i != adc_ovr_pkg::FLAG_SEL_NONE);
	// index capture in the flag cycle
	assign index_d = cmd_flagged ? cmd_index_i : interrupt_index_capture_o;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			interrupt_index_capture_o <= adc_ovr_pkg::INDEX_RESET;
		end else begin
			interrupt_index_capture_o <= index_d;
		end
	end

	// one sticky flag per selectable code
	for (genvar g = adc_ovr_pkg::FLAG_LO; g <= adc_ovr_pkg::FLAG_HI; g++) begin : g_done
		logic hit;
		assign hit = cmd_flagged & (flag_select_field_i == g[adc_ovr_pkg::FLAG_SEL_W-1:0]);
		sticky_flag u_done_flag (
			.clk_i     (clk_i),
			.reset_n_i (reset_n_i),
			.set_i     (hit),
			.clear_i   (done_flag_clear_i[g]),
			.flag_o    (conversion_done_flags_o[g])
		);
	end

	chk_index_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cmd_flagged |=> (interrupt_index_capture_o == $past(cmd_index_i))
		&& (conversion_done_flags_o[$past(flag_select_field_i)])) else $error("index or flag wrong");

endmodule : adc_sequence_overrun_control

//--- adc_sequence_overrun_control_tb.sv
// self-checking bench for the sequence overrun control
`timescale 1ns/1ns
module adc_sequence_overrun_control_tb;
	localparam logic [7:0] RR = 8'h01, BR = 8'h02, IR = 8'h04, CS = 8'h08;
	localparam logic [7:0] BD = 8'h10, OC = 8'h20, AR = 8'h40, CM = 8'h80;
	logic       clk_i = 1'b0;
	logic       reset_n_i = 1'b0;
	logic [7:0] pv = 8'h00;
	logic       rc = 1'b0;
	logic       auto_q = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [adc_ovr_pkg::FLAG_SEL_W-1:0] fsel = 4'h0;
	logic [adc_ovr_pkg::CMD_INDEX_W-1:0] cidx = 6'h00;
	logic [adc_ovr_pkg::FLAG_HI:adc_ovr_pkg::FLAG_LO] fclr = 15'h0000;
	logic r_act, r_pend, r_bg, r_start, r_rel, r_ovr, c_pend, e_flag, halt, a_prog, a_start, a_disc, rd, ad;
	logic [adc_ovr_pkg::CMD_INDEX_W-1:0] idx_cap;
	logic [adc_ovr_pkg::FLAG_HI:adc_ovr_pkg::FLAG_LO] dflags;
	int   err_total = 0;
	int   num_checks = 0;
	logic start_q[$];

	always #2 clk_i = ~clk_i;

	adc_sequence_overrun_control dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .restart_req_i(pv[0]),
		.restart_done_i(rd), .reload_confirm_i(rc), .auto_request_mode_i(auto_q), .conv_req_bus_i(pv[1]),
		.conv_req_intf_i(pv[2]), .conv_start_i(pv[3]), .conv_boundary_i(pv[4]), .overrun_clear_i(pv[5]),
		.abort_req_i(pv[6]), .abort_done_i(ad), .cmd_stored_i(pv[7]), .flag_select_field_i(fsel),
		.cmd_index_i(cidx), .done_flag_clear_i(fclr), .restart_active_o(r_act), .restart_pending_o(r_pend),
		.reload_confirm_bg_o(r_bg), .restart_start_o(r_start), .restart_reload_o(r_rel),
		.restart_overrun_o(r_ovr), .conversion_request_pending_o(c_pend), .request_overrun_error_flag_o(e_flag),
		.halt_o(halt), .abort_in_progress_o(a_prog), .abort_start_o(a_start), .abort_discard_o(a_disc),
		.interrupt_index_capture_o(idx_cap), .conversion_done_flags_o(dflags));

	adc_far_end_model far (.clk_i(clk_i), .reset_n_i(reset_n_i), .restart_active_i(r_act),
		.abort_in_progress_i(a_prog), .delay_i(dly), .restart_done_o(rd), .abort_done_o(ad));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp, input string msg);
		chk({15'h0000, got}, {15'h0000, exp}, msg);
	endtask : chkb

	// pulses stand one cycle unless the next step repeats them
	task automatic step(input logic [7:0] p);
		pv = p;
		@(negedge clk_i);
	endtask : step

	// the replay gap shows active low for one cycle, so idle must hold twice
	task automatic wait_idle();
		int n;
		int quiet;
		n = 0;
		quiet = 0;
		while (quiet < 2 && n < 60) begin
			@(negedge clk_i);
			n++;
			quiet = (r_act === 1'b0 && a_prog === 1'b0) ? quiet + 1 : 0;
		end
		chkb(quiet == 2, 1'b1, "event never finished");
	endtask : wait_idle

	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// each restart start takes the oldest noted reload state
	always @(negedge clk_i) begin
		if (r_start === 1'b1) begin
			if (start_q.size() == 0) chkb(1'b1, 1'b0, "restart start without a note");
			else chkb(r_rel, start_q.pop_front(), "restart reload state");
		end
	end

	initial begin
		#20000;
		err_total++;
		$display("unexpected at %0t: run timed out", $time);
		conclude();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		logic [2:0]  pat;
		logic        bg;
		logic [5:0]  prev;
		logic [15:0] m;
		int          n;
		void'($urandom(32'h29dd));
		repeat (2) @(negedge clk_i);
		reset_n_i = 1'b1;
		chk(16'({r_act, r_pend, r_bg, r_start, r_ovr, c_pend, e_flag, halt, a_prog, a_start, a_disc}), 16'h0000, "reset");
		chk(16'({idx_cap, dflags}), 16'h0000, "reset index and flags");
		dly = 4'h9;
		rc = 1'($urandom);
		start_q.push_back(rc);
		step(RR);
		chkb(r_act & r_start, 1'b1, "fresh restart");
		bg = 1'b0;
		pat = 3'($urandom);
		for (int i = 0; i < 3; i++) begin
			rc = pat[i];
			bg = bg | pat[i];
			step(RR);
			chkb(r_ovr & r_pend & r_act & !r_start, 1'b1, "restart overrun");
			chkb(r_bg, bg, "reload background");
		end
		rc = 1'b0;
		start_q.push_back(bg);
		step(8'h00);
		n = 0;
		while (r_act === 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chkb(r_pend | r_bg | r_act, 1'b0, "pending restart taken");
		@(negedge clk_i);
		chkb(r_act & r_start, 1'b1, "replay one cycle later");
		wait_idle();
		auto_q = 1'b1;
		dly = 4'h3;
		start_q.push_back(1'b0);
		step(RR);
		chkb(c_pend, 1'b1, "hardware request in auto mode");
		start_q.push_back(1'b0);
		step(RR);
		chkb(r_ovr & !e_flag, 1'b1, "restart overrun is no request overrun");
		step(CS);
		step(8'h00);
		wait_idle();
		step(CS);
		chkb(e_flag | halt | c_pend, 1'b0, "replay request consumed");
		start_q.push_back(1'b0);
		step(RR | BR);
		chkb(e_flag & halt, 1'b1, "coincident requests halt");
		// software clears while the restart is still active
		step(OC | CS);
		chkb(e_flag | halt, 1'b0, "collision cleared");
		step(8'h00);
		wait_idle();
		auto_q = 1'b0;
		step(BR);
		step(IR);
		chkb(e_flag & !halt, 1'b1, "request while pending");
		step(BD);
		chkb(halt, 1'b1, "halt at boundary");
		repeat (5) step(8'h00);
		chkb(e_flag & halt, 1'b1, "flag holds");
		step(OC);
		chkb(e_flag | halt, 1'b0, "flag cleared");
		step(BR | CS);
		chkb(c_pend & !e_flag, 1'b1, "request with start is no overrun");
		step(CS);
		chkb(c_pend, 1'b0, "request consumed");
		dly = 4'h4;
		step(AR);
		chkb(a_start & a_prog, 1'b1, "abort starts");
		step(AR);
		chkb(a_disc & !a_start & a_prog, 1'b1, "abort discarded");
		step(8'h00);
		wait_idle();
		prev = 6'h00;
		m = 16'h0000;
		for (int s = 0; s < 16; s++) begin
			fsel = 4'(s);
			cidx = 6'($urandom);
			step(CM);
			if (s != 0) begin
				prev = cidx;
				m = m | (16'h0001 << (s - 1));
			end
			chk(16'(idx_cap), 16'(prev), "index capture");
			chk(16'(dflags), m, "done flags");
		end
		fclr = 15'($urandom);
		m = m & ~16'(fclr);
		step(8'h00);
		fclr = 15'h0000;
		chk(16'(dflags), m, "done flags cleared");
		step(8'h00);
		chkb(start_q.size() == 0, 1'b1, "restart notes left over");
		conclude();
	end
endmodule : adc_sequence_overrun_control_tb

//--- sticky_flag.sv
// one status flag that hardware sets and a clear strobe resets
`timescale 1ns/1ns
module sticky_flag (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// set and clear strobes
	input  wire logic set_i,
	input  wire logic clear_i,
	// flag
	output logic      flag_o
);

	// ------------------------------------------------------------
	// flag storage
	// ------------------------------------------------------------
	logic flag_d;

	// a set in the clearing cycle wins so no event is lost
	assign flag_d = set_i | (flag_o & ~clear_i);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_o <= adc_ovr_pkg::BIT_RESET;
		end else begin
			flag_o <= flag_d;
		end
	end

	chk_set_wins_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		set_i |=> flag_o) else $error("flag not set after set strobe");
	chk_hold_no_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(flag_o && !clear_i) |=> flag_o) else $error("flag dropped without clear");

endmodule : sticky_flag
